//--- pkg/lbc_pkg.sv
`default_nettype none
package lbc_pkg;

	// Address map
	localparam logic [8:0] LBC_ADDR_PRIMARY = 9'h080;
	localparam logic [8:0] LBC_ADDR_TBL1_ROW = 9'h081;
	localparam logic [8:0] LBC_ADDR_TBL2_ROW = 9'h082;
	localparam logic [8:0] LBC_ADDR_CONV1_VAL = 9'h083;
	localparam logic [8:0] LBC_ADDR_STATUS = 9'h087;

	// Protected partitions
	localparam logic [8:0] LBC_GENMEM_LAST = 9'h07F;
	localparam logic [8:0] LBC_TBL1_FIRST = 9'h090;
	localparam logic [8:0] LBC_TBL1_LAST = 9'h0CF;
	localparam logic [8:0] LBC_TBL2_FIRST = 9'h0D0;
	localparam logic [8:0] LBC_TBL2_LAST = 9'h10F;

	// Lookup table bases
	localparam logic [8:0] LBC_TBL1_BASE = 9'h090;
	localparam logic [8:0] LBC_TBL2_BASE = 9'h0D0;

	// Lock field codes
	localparam logic [1:0] LBC_LOCK_NONE = 2'h0;
	localparam logic [1:0] LBC_LOCK_GENMEM = 2'h1;
	localparam logic [1:0] LBC_LOCK_TBL1 = 2'h2;
	localparam logic [1:0] LBC_LOCK_TBL2 = 2'h3;

	// Primary control byte fields
	localparam int LBC_LOCK_LSB = 0;
	localparam int LBC_LOCK_MSB = 1;
	localparam int LBC_REF_MODE_BIT = 2;
	localparam int LBC_CONV_SRC_BIT = 3;
	localparam int LBC_FILT_OFF_BIT = 4;
	localparam int LBC_PERSIST_BIT = 5;
	localparam int LBC_GEN1_DIR_BIT = 6;
	localparam int LBC_GEN2_DIR_BIT = 7;

	// Row select field and status layout
	localparam logic [7:0] LBC_ROW_MASK = 8'h3F;
	localparam int LBC_STATUS_LSB = 2;

	// Reset values (factory cells are zero)
	localparam logic [7:0] LBC_RESET_BYTE = 8'h00;
	localparam logic [5:0] LBC_RESET_RESULT = 6'h00;

	// Filter needs four equal results: count reaches three matches
	localparam logic [1:0] LBC_FILT_MATCHES = 2'h3;

	typedef enum logic [1:0] {
		LBC_ST_RESTORE = 2'b01,
		LBC_ST_RUN = 2'b10
	} lbc_state_e;

endpackage : lbc_pkg
`default_nettype wire

//--- src/lbc_result_filter.sv
`timescale 1ns/1ps
`default_nettype none
module lbc_result_filter
	import lbc_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_conv_valid,
	input wire logic [5:0] i_conv_result,
	input wire logic i_filter_off,
	output logic [5:0] o_result
);

	logic [5:0] prev;
	logic [1:0] match_cnt;
	logic [5:0] next_prev;
	logic [1:0] next_match_cnt;
	logic [5:0] next_result;

	always_comb begin
		next_prev = prev;
		next_match_cnt = match_cnt;
		next_result = o_result;
		if (i_conv_valid) begin
			next_prev = i_conv_result;
			if (i_conv_result != prev) begin
				next_match_cnt = 2'h0;
			end else if (match_cnt != LBC_FILT_MATCHES) begin
				next_match_cnt = match_cnt + 2'h1;
			end
			if (i_filter_off || next_match_cnt == LBC_FILT_MATCHES) begin
				next_result = i_conv_result;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			prev <= LBC_RESET_RESULT;
			match_cnt <= 2'h0;
			o_result <= LBC_RESET_RESULT;
		end else begin
			prev <= next_prev;
			match_cnt <= next_match_cnt;
			o_result <= next_result;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	a_filter_off_update: assert property (
		i_conv_valid && i_filter_off |=> o_result == $past(i_conv_result))
		else $error("unfiltered result not taken");
	a_filter_hold_mismatch: assert property (
		i_conv_valid && !i_filter_off && i_conv_result != prev |=> $stable(o_result))
		else $error("status changed on a mismatching result");
	a_filter_four_equal: assert property (
		!i_filter_off && i_conv_valid ##1 (i_conv_valid && $stable(i_conv_result)) [*3]
		##0 !i_filter_off |=> o_result == $past(i_conv_result))
		else $error("four equal results did not update status");
	c_filter_update: cover property (!i_filter_off && i_conv_valid ##1 $changed(o_result));

endmodule : lbc_result_filter
`default_nettype wire

//--- src/lbc_config_regs.sv
// Functional notes
// - Lock field chooses which partitions are protected
// - Write into protected region is abandoned whole
// - Write-protect low blocks every write
// - Reference-mode bit sets reference pin direction
// - Converter-input bit picks sensor or sense pin
// - Filter bit: update always or after four
// - Persistence bit sends bytes 1-3 to nonvolatile
// - Direction bits: zero sources, one sinks
// - Primary control byte at 80h, fixed layout
// - Table one row plus base 90h when direct
// - Table two row plus base D0h when direct
// - Converter one takes byte 83h when direct
`timescale 1ns/1ps
`default_nettype none
module lbc_config_regs
	import lbc_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_wr_req,
	input wire logic i_rd_req,
	input wire logic [8:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write_protect_n,
	input wire logic [7:0] i_nv_primary,
	input wire logic [7:0] i_nv_tbl1_row,
	input wire logic [7:0] i_nv_tbl2_row,
	input wire logic [7:0] i_nv_conv1_value,
	input wire logic i_tbl1_direct_en,
	input wire logic i_tbl2_direct_en,
	input wire logic i_conv1_direct_en,
	input wire logic i_conv_valid,
	input wire logic [5:0] i_conv_result,
	input wire logic [7:0] i_tbl1_row_data,
	output logic [7:0] o_rdata,
	output logic o_rd_valid,
	output logic o_array_wr,
	output logic o_nv_wr,
	output logic o_wr_abort,
	output logic [8:0] o_wr_addr,
	output logic [7:0] o_wr_data,
	output logic o_ref_pin_input,
	output logic o_conv_src_sense,
	output logic o_gen1_sink,
	output logic o_gen2_sink,
	output logic [8:0] o_tbl1_addr,
	output logic [8:0] o_tbl2_addr,
	output logic [7:0] o_conv1_value,
	output logic [7:0] o_status,
	output logic o_ready
);

	lbc_state_e state;
	lbc_state_e next_state;
	logic [7:0] primary_config;
	logic [7:0] table_one_row_select;
	logic [7:0] table_two_row_select;
	logic [7:0] converter_one_direct_value;
	logic [7:0] next_primary_config;
	logic [7:0] next_table_one_row_select;
	logic [7:0] next_table_two_row_select;
	logic [7:0] next_converter_one_direct_value;
	logic [7:0] next_rdata;
	logic next_rd_valid;
	logic next_array_wr;
	logic next_nv_wr;
	logic next_wr_abort;
	logic [8:0] next_wr_addr;
	logic [7:0] next_wr_data;
	logic [8:0] next_tbl1_addr;
	logic [8:0] next_tbl2_addr;
	logic [7:0] next_conv1_value;
	logic [5:0] filt_result;
	logic [1:0] lock_field;
	logic in_genmem;
	logic in_tbl1;
	logic in_tbl2;
	logic locked_hit;
	logic run;
	logic is_direct_reg;

	assign lock_field = primary_config[LBC_LOCK_MSB:LBC_LOCK_LSB];
	assign run = (state == LBC_ST_RUN);
	assign in_genmem = (i_addr <= LBC_GENMEM_LAST);
	assign in_tbl1 = (i_addr >= LBC_TBL1_FIRST) && (i_addr <= LBC_TBL1_LAST);
	assign in_tbl2 = (i_addr >= LBC_TBL2_FIRST) && (i_addr <= LBC_TBL2_LAST);
	assign is_direct_reg = (i_addr >= LBC_ADDR_TBL1_ROW) && (i_addr <= LBC_ADDR_CONV1_VAL);

	always_comb begin
		if (lock_field == LBC_LOCK_GENMEM) begin
			locked_hit = in_genmem;
		end else if (lock_field == LBC_LOCK_TBL1) begin
			locked_hit = in_genmem || in_tbl1;
		end else if (lock_field == LBC_LOCK_TBL2) begin
			locked_hit = in_genmem || in_tbl1 || in_tbl2;
		end else begin
			locked_hit = 1'b0;
		end
	end

	// Power-up restore, then normal access
	always_comb begin
		next_state = state;
		case (state)
			LBC_ST_RESTORE: begin
				next_state = LBC_ST_RUN;
			end
			LBC_ST_RUN: begin
				next_state = LBC_ST_RUN;
			end
			default: begin
				next_state = LBC_ST_RESTORE;
			end
		endcase
	end

	always_comb begin
		next_primary_config = primary_config;
		next_table_one_row_select = table_one_row_select;
		next_table_two_row_select = table_two_row_select;
		next_converter_one_direct_value = converter_one_direct_value;
		next_array_wr = 1'b0;
		next_nv_wr = 1'b0;
		next_wr_abort = 1'b0;
		next_wr_addr = o_wr_addr;
		next_wr_data = o_wr_data;
		if (state == LBC_ST_RESTORE) begin
			next_primary_config = i_nv_primary;
			next_table_one_row_select = i_nv_tbl1_row & LBC_ROW_MASK;
			next_table_two_row_select = i_nv_tbl2_row & LBC_ROW_MASK;
			next_converter_one_direct_value = i_nv_conv1_value;
		end else if (i_wr_req) begin
			next_wr_addr = i_addr;
			next_wr_data = i_wdata;
			if (!i_write_protect_n) begin
				next_wr_abort = 1'b1;
			end else if (locked_hit) begin
				next_wr_abort = 1'b1;
			end else if (i_addr == LBC_ADDR_PRIMARY) begin
				next_primary_config = i_wdata;
				next_nv_wr = 1'b1;
			end else if (is_direct_reg) begin
				if (i_addr == LBC_ADDR_TBL1_ROW) begin
					next_table_one_row_select = i_wdata & LBC_ROW_MASK;
				end else if (i_addr == LBC_ADDR_TBL2_ROW) begin
					next_table_two_row_select = i_wdata & LBC_ROW_MASK;
				end else begin
					next_converter_one_direct_value = i_wdata;
				end
				next_nv_wr = primary_config[LBC_PERSIST_BIT];
			end else if (i_addr != LBC_ADDR_STATUS) begin
				next_array_wr = 1'b1;
			end
		end
	end

	always_comb begin
		next_rd_valid = run && i_rd_req;
		next_rdata = LBC_RESET_BYTE;
		if (i_addr == LBC_ADDR_PRIMARY) begin
			next_rdata = primary_config;
		end else if (i_addr == LBC_ADDR_TBL1_ROW) begin
			next_rdata = table_one_row_select;
		end else if (i_addr == LBC_ADDR_TBL2_ROW) begin
			next_rdata = table_two_row_select;
		end else if (i_addr == LBC_ADDR_CONV1_VAL) begin
			next_rdata = converter_one_direct_value;
		end else if (i_addr == LBC_ADDR_STATUS) begin
			next_rdata = o_status;
		end
		if (!next_rd_valid) begin
			next_rdata = o_rdata;
		end
	end

	always_comb begin
		if (i_tbl1_direct_en) begin
			next_tbl1_addr = LBC_TBL1_BASE + {3'h0, table_one_row_select[5:0]};
		end else begin
			next_tbl1_addr = LBC_TBL1_BASE + {3'h0, filt_result};
		end
		if (i_tbl2_direct_en) begin
			next_tbl2_addr = LBC_TBL2_BASE + {3'h0, table_two_row_select[5:0]};
		end else begin
			next_tbl2_addr = LBC_TBL2_BASE + {3'h0, filt_result};
		end
		if (i_conv1_direct_en) begin
			next_conv1_value = converter_one_direct_value;
		end else begin
			next_conv1_value = i_tbl1_row_data;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= LBC_ST_RESTORE;
			primary_config <= LBC_RESET_BYTE;
			table_one_row_select <= LBC_RESET_BYTE;
			table_two_row_select <= LBC_RESET_BYTE;
			converter_one_direct_value <= LBC_RESET_BYTE;
			o_rdata <= LBC_RESET_BYTE;
			o_rd_valid <= 1'b0;
			o_array_wr <= 1'b0;
			o_nv_wr <= 1'b0;
			o_wr_abort <= 1'b0;
			o_wr_addr <= 9'h000;
			o_wr_data <= LBC_RESET_BYTE;
			o_ref_pin_input <= 1'b0;
			o_conv_src_sense <= 1'b0;
			o_gen1_sink <= 1'b0;
			o_gen2_sink <= 1'b0;
			o_tbl1_addr <= LBC_TBL1_BASE;
			o_tbl2_addr <= LBC_TBL2_BASE;
			o_conv1_value <= LBC_RESET_BYTE;
			o_status <= LBC_RESET_BYTE;
			o_ready <= 1'b0;
		end else begin
			state <= next_state;
			primary_config <= next_primary_config;
			table_one_row_select <= next_table_one_row_select;
			table_two_row_select <= next_table_two_row_select;
			converter_one_direct_value <= next_converter_one_direct_value;
			o_rdata <= next_rdata;
			o_rd_valid <= next_rd_valid;
			o_array_wr <= next_array_wr;
			o_nv_wr <= next_nv_wr;
			o_wr_abort <= next_wr_abort;
			o_wr_addr <= next_wr_addr;
			o_wr_data <= next_wr_data;
			o_ref_pin_input <= next_primary_config[LBC_REF_MODE_BIT];
			o_conv_src_sense <= next_primary_config[LBC_CONV_SRC_BIT];
			o_gen1_sink <= next_primary_config[LBC_GEN1_DIR_BIT];
			o_gen2_sink <= next_primary_config[LBC_GEN2_DIR_BIT];
			o_tbl1_addr <= next_tbl1_addr;
			o_tbl2_addr <= next_tbl2_addr;
			o_conv1_value <= next_conv1_value;
			o_status <= {filt_result, 2'h0};
			o_ready <= (next_state == LBC_ST_RUN);
		end
	end

	lbc_result_filter u_filter (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_conv_valid(i_conv_valid),
		.i_conv_result(i_conv_result),
		.i_filter_off(primary_config[LBC_FILT_OFF_BIT]),
		.o_result(filt_result)
	);

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	a_wp_blocks_write: assert property (
		run && i_wr_req && !i_write_protect_n |=> o_wr_abort && !o_array_wr && !o_nv_wr)
		else $error("write passed while protect pin low");
	a_lock_genmem_abort: assert property (
		run && i_wr_req && lock_field != LBC_LOCK_NONE && i_addr <= LBC_GENMEM_LAST
		|=> o_wr_abort && !o_array_wr)
		else $error("locked general memory write not abandoned");
	a_lock_tbl2_abort: assert property (
		run && i_wr_req && lock_field == LBC_LOCK_TBL2 && i_addr >= LBC_TBL2_FIRST
		&& i_addr <= LBC_TBL2_LAST |=> o_wr_abort && !o_array_wr)
		else $error("locked table two write not abandoned");
	a_lock_tbl2_open: assert property (
		run && i_wr_req && i_write_protect_n && lock_field == LBC_LOCK_TBL1
		&& i_addr == LBC_TBL2_FIRST |=> o_array_wr && !o_wr_abort)
		else $error("table two wrongly locked");
	a_ref_mode_follow: assert property (
		run && i_wr_req && i_write_protect_n && i_addr == LBC_ADDR_PRIMARY
		|=> o_ref_pin_input == $past(i_wdata[LBC_REF_MODE_BIT])
		&& o_gen2_sink == $past(i_wdata[LBC_GEN2_DIR_BIT]))
		else $error("primary byte fields not applied");
	a_volatile_only: assert property (
		run && i_wr_req && i_write_protect_n && is_direct_reg
		&& !primary_config[LBC_PERSIST_BIT] |=> !o_nv_wr)
		else $error("volatile write reached nonvolatile cells");
	a_persist_write: assert property (
		run && i_wr_req && i_write_protect_n && is_direct_reg
		&& primary_config[LBC_PERSIST_BIT] |=> o_nv_wr && o_wr_addr == $past(i_addr))
		else $error("persistent write missing");
	a_tbl1_direct_addr: assert property (
		i_tbl1_direct_en |=> o_tbl1_addr == LBC_TBL1_BASE + {3'h0, $past(table_one_row_select[5:0])})
		else $error("table one direct address wrong");
	a_conv1_direct: assert property (
		i_conv1_direct_en |=> o_conv1_value == $past(converter_one_direct_value))
		else $error("converter one direct value wrong");
	c_abort_seen: cover property (run && i_wr_req ##1 o_wr_abort);
	c_persist_seen: cover property (o_nv_wr && o_wr_addr == LBC_ADDR_TBL2_ROW);
	c_read_status: cover property (run && i_rd_req && i_addr == LBC_ADDR_STATUS ##1 o_rd_valid);

endmodule : lbc_config_regs
`default_nettype wire

//--- verification/lbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lbc_host_model (
	input wire logic i_mclk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rd_valid,
	input wire logic i_array_wr,
	input wire logic i_nv_wr,
	input wire logic i_wr_abort,
	output logic o_wr_req,
	output logic o_rd_req,
	output logic [8:0] o_addr,
	output logic [7:0] o_wdata
);
	initial begin
		o_wr_req = 1'b0;
		o_rd_req = 1'b0;
		o_addr = 9'h000;
		o_wdata = 8'h00;
	end

	// Byte write, answer flags {abort, nv, array}
	task automatic write_byte(input logic [8:0] a, input logic [7:0] d, output logic [2:0] f);
		@(posedge i_mclk);
		#2;
		o_wr_req = 1'b1;
		o_addr = a;
		o_wdata = (a == 9'h081 || a == 9'h082) ? (d & 8'h3F) : d;
		@(posedge i_mclk);
		#2;
		f = {i_wr_abort, i_nv_wr, i_array_wr};
		o_wr_req = 1'b0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask : write_byte

	// Byte read, unknown when no valid strobe
	task automatic read_byte(input logic [8:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		#2;
		o_rd_req = 1'b1;
		o_addr = a;
		@(posedge i_mclk);
		#2;
		d = (i_rd_valid === 1'b1) ? i_rdata : 8'hXX;
		o_rd_req = 1'b0;
		o_addr = ~o_addr;
	endtask : read_byte
endmodule : lbc_host_model
`default_nettype wire

//--- verification/laser_bias_config_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module laser_bias_config_registers_tb;
	logic clk, rstn, wpn, t1en, t2en, c1en, cv;
	logic [5:0] cres;
	logic [7:0] nvp, nv3, nvr, rdata, wdat, conv1, status, rowd, wdout;
	logic [8:0] addr, waddr, t1a, t2a;
	logic wrq, rdq, rdv, arw, nvw, abt, refi, srcs, g1, g2, rdy, prot;
	int errors = 0;
	int check_count = 0;
	int n;
	logic [8:0] la [7] = '{9'h000, 9'h07F, 9'h090, 9'h0CF, 9'h0D0, 9'h10F, 9'h084};
	logic [7:0] pat [6] = '{8'hCC, 8'h80, 8'h40, 8'h08, 8'h04, 8'h00};
	logic [5:0] fs [12] = '{6'h0A, 6'h0A, 6'h0A, 6'h0A, 6'h0B, 6'h0B, 6'h0B, 6'h0C,
		6'h0B, 6'h0B, 6'h0B, 6'h0B};

	// Array side: row byte follows the table address
	assign rowd = t1a[7:0] ^ 8'h3C;

	lbc_config_regs u_lbc_config_regs (
		.i_mclk(clk), .i_resetn(rstn), .i_wr_req(wrq), .i_rd_req(rdq), .i_addr(addr),
		.i_wdata(wdat), .i_write_protect_n(wpn), .i_nv_primary(nvp), .i_nv_tbl1_row(nvr),
		.i_nv_tbl2_row(nvr), .i_nv_conv1_value(nv3), .i_tbl1_direct_en(t1en),
		.i_tbl2_direct_en(t2en), .i_conv1_direct_en(c1en), .i_conv_valid(cv),
		.i_conv_result(cres), .i_tbl1_row_data(rowd), .o_rdata(rdata), .o_rd_valid(rdv),
		.o_array_wr(arw), .o_nv_wr(nvw), .o_wr_abort(abt), .o_wr_addr(waddr),
		.o_wr_data(wdout), .o_ref_pin_input(refi), .o_conv_src_sense(srcs), .o_gen1_sink(g1),
		.o_gen2_sink(g2), .o_tbl1_addr(t1a), .o_tbl2_addr(t2a), .o_conv1_value(conv1),
		.o_status(status), .o_ready(rdy)
	);

	lbc_host_model u_lbc_host_model (
		.i_mclk(clk), .i_rdata(rdata), .i_rd_valid(rdv), .i_array_wr(arw), .i_nv_wr(nvw),
		.i_wr_abort(abt), .o_wr_req(wrq), .o_rd_req(rdq), .o_addr(addr), .o_wdata(wdat)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk_flags(input logic [2:0] got, input logic [2:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_flags

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_addr(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_addr

	task automatic wr_chk(input logic [8:0] a, input logic [7:0] d, input logic [2:0] ef);
		logic [2:0] f;
		u_lbc_host_model.write_byte(a, d, f);
		chk_flags(f, ef);
	endtask : wr_chk

	task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_lbc_host_model.read_byte(a, d);
		chk_byte(d, exp);
	endtask : rd_chk

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask : tick

	task automatic conv(input logic [5:0] r, input int k);
		@(posedge clk);
		#2;
		cv = 1'b1;
		cres = r;
		tick(k);
		cv = 1'b0;
		tick(2);
	endtask : conv

	task automatic final_report();
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	initial begin
		#100000;
		errors++;
		final_report();
	end

	initial begin
		{rstn, t1en, t2en, c1en, cv} = 5'b00000;
		wpn = 1'b1;
		cres = 6'h00;
		nvp = 8'h04;
		nv3 = 8'h5A;
		nvr = 8'hC7;
		tick(6);
		chk_addr(t1a, 9'h090);
		chk_addr(t2a, 9'h0D0);
		rstn = 1'b1;
		n = 0;
		while (rdy !== 1'b1 && n < 10) begin
			tick(1);
			n++;
		end
		chk_flags({2'b00, rdy}, 3'b001);
		chk_flags({2'b00, refi}, 3'b001);
		rd_chk(9'h083, 8'h5A);
		rd_chk(9'h081, 8'h07);
		rd_chk(9'h082, 8'h07);
		foreach (pat[i]) begin
			wr_chk(9'h080, pat[i], 3'b010);
			chk_byte({4'h0, g2, g1, srcs, refi}, {4'h0, pat[i][7:6], pat[i][3:2]});
			rd_chk(9'h080, pat[i]);
		end
		for (int lk = 0; lk < 4; lk++) begin
			wr_chk(9'h080, 8'(lk), 3'b010);
			foreach (la[i]) begin
				prot = (lk != 0 && la[i] <= 9'h07F) || (lk >= 2 && la[i] >= 9'h090
					&& la[i] <= 9'h0CF) || (lk == 3 && la[i] >= 9'h0D0);
				wr_chk(la[i], 8'h11, prot ? 3'b100 : 3'b001);
			end
		end
		wr_chk(9'h080, 8'h00, 3'b010);
		wpn = 1'b0;
		wr_chk(9'h080, 8'hFF, 3'b100);
		wr_chk(9'h010, 8'h01, 3'b100);
		wpn = 1'b1;
		rd_chk(9'h080, 8'h00);
		wr_chk(9'h080, 8'h10, 3'b010);
		conv(6'h15, 1);
		chk_byte(status, 8'h54);
		wr_chk(9'h080, 8'h00, 3'b010);
		foreach (fs[i]) begin
			conv(fs[i], 1);
			chk_byte(status, (i < 3) ? 8'h54 : (i < 11) ? 8'h28 : 8'h2C);
		end
		chk_addr(t1a, 9'h09B);
		chk_addr(t2a, 9'h0DB);
		t1en = 1'b1;
		wr_chk(9'h081, 8'hFF, 3'b000);
		tick(2);
		chk_addr(t1a, 9'h0CF);
		t2en = 1'b1;
		wr_chk(9'h082, 8'h05, 3'b000);
		tick(2);
		chk_addr(t2a, 9'h0D5);
		c1en = 1'b1;
		wr_chk(9'h083, 8'hA5, 3'b000);
		tick(2);
		chk_byte(conv1, 8'hA5);
		c1en = 1'b0;
		tick(2);
		chk_byte(conv1, 8'hF3);
		wr_chk(9'h080, 8'h20, 3'b010);
		wr_chk(9'h082, 8'h06, 3'b010);
		chk_addr(waddr, 9'h082);
		chk_byte(wdout, 8'h06);
		rd_chk(9'h082, 8'h06);
		conv(6'h07, 4);
		chk_byte(status, 8'h1C);
		final_report();
	end
endmodule : laser_bias_config_registers_tb
`default_nettype wire
